// ---- design/dms_addr_match.v ----
/*
 Address comparator for the four first/second byte match pairs.
 Assumes both received address bytes are held stable by the caller.
*/
`default_nettype none
`include "dms_defines.vh"

module dms_addr_match
#(
   parameter PAIRS = 4
)
(
   // Received address bytes
   input wire [7:0] byte_one_i,
   input wire [7:0] byte_two_i,
   // Match values, pair n in bits 8n+7:8n
   input wire [8*PAIRS-1:0] first_match_i,
   input wire [8*PAIRS-1:0] second_match_i,
   // Controls
   input wire [PAIRS-1:0] pair_en_i,
   input wire single_i,
   input wire second_only_i,
   input wire cr_cmp_i,
   // Result
   output wire [PAIRS-1:0] match_o
);

   wire [7:0] mask;

   // Command/response bit ignored unless asked for
   assign mask = cr_cmp_i ? `DMS_CR_MASK_ON : `DMS_CR_MASK_OFF;

   genvar n;
   generate
      for (n = 0; n < PAIRS; n = n + 1)
      begin : g_pair
         wire hit_one;
         wire hit_two;
         assign hit_one = ((byte_one_i ^ first_match_i[8*n+7:8*n]) & mask)
                          == 8'h00;
         assign hit_two = byte_two_i == second_match_i[8*n+7:8*n];
         assign match_o[n] = pair_en_i[n] & (!single_i ?
                             (hit_one & hit_two) :
                             (second_only_i ? hit_two : hit_one));
      end
   endgenerate

endmodule

`default_nettype wire

// ---- design/dms_defines.vh ----
/*
 Register offsets, field positions, reset values and threshold table
 entries of the D-channel mode and status logic.
 Assumes inclusion by bare name from the design files.
*/
// Behaviour
// - Receive threshold code picks 1/2/4/8 or 1/16/24/30
// - Transmit threshold code picks 1/2/4/8 or 1/6/10/14
// - Bit 4 chooses mark idle or flag idle
// - Bit 5/7 choose two-byte, first-only, second-only matching
// - Bit 6 includes command/response bit in compare
// - Address status bit n-1 flags pair n match
// - Status bit 0 two bytes after opening flag if an enabled pair matches or no pair is enabled
// - Status bit 1 on closing flag received
// - Status bit 2 one byte after opening flag
// - Status bits 3/4 show loopback locations live
// - Status bit 5 high while back-off inactive
// - Status bit 6 on closing flag transmitted
// - Status bit 7 after transmit abort sequence sent
// - Reset or idle clears all status bits
// - Address and transmit-end interrupt enables default on
// - Extended FIFO control bit 0 selects extended tables
`ifndef DMS_DEFINES_VH
`define DMS_DEFINES_VH

`define DMS_ADDR_XMIT_COUNT 8'h85
`define DMS_ADDR_MODE_ONE 8'h86
`define DMS_ADDR_RECV_COUNT 8'h89
`define DMS_ADDR_MODE_THREE 8'h8E
`define DMS_ADDR_MODE_FOUR 8'h8F
`define DMS_ADDR_STATUS_ONE 8'h90
`define DMS_ADDR_ADDR_STATUS 8'h91
`define DMS_ADDR_EXT_FIFO 8'h92

`define DMS_MODE_ONE_RST 8'h00
`define DMS_MODE_THREE_RST 8'h03
`define DMS_MODE_FOUR_RST 8'h00
`define DMS_EXT_FIFO_RST 8'h00

`define DMS_M1_EOP_IE 3
`define DMS_M3_ADDR_IE 0
`define DMS_M3_TXEND_IE 1
`define DMS_M4_FILL 4
`define DMS_M4_SINGLE 5
`define DMS_M4_CR_CMP 6
`define DMS_M4_SECOND 7
`define DMS_EF_EXT 0

`define DMS_S_ADDR 0
`define DMS_S_EOP 1
`define DMS_S_RIP 2
`define DMS_S_LOOP_IN 3
`define DMS_S_LOOP_LIU 4
`define DMS_S_NO_BACKOFF 5
`define DMS_S_TXEND 6
`define DMS_S_TXABORT 7

`define DMS_CR_MASK_OFF 8'hFD
`define DMS_CR_MASK_ON 8'hFF

`define DMS_RX_N0 5'h01
`define DMS_RX_N1 5'h02
`define DMS_RX_N2 5'h04
`define DMS_RX_N3 5'h08
`define DMS_RX_E0 5'h01
`define DMS_RX_E1 5'h10
`define DMS_RX_E2 5'h18
`define DMS_RX_E3 5'h1E
`define DMS_TX_N0 4'h1
`define DMS_TX_N1 4'h2
`define DMS_TX_N2 4'h4
`define DMS_TX_N3 4'h8
`define DMS_TX_E0 4'h1
`define DMS_TX_E1 4'h6
`define DMS_TX_E2 4'hA
`define DMS_TX_E3 4'hE

`endif

// ---- design/dms_status_logic.v ----
/*
 D-channel mode register four, address status, status register one,
 and the mode one/three and extended FIFO control bits they depend on.
 Assumes an indirect register port on the system clock, and receive
 and transmit framing events as single-cycle pulses from logic on the
 same clock; loopback and back-off levels come from off this clock.
*/
`default_nettype none
`include "dms_defines.vh"

module dms_status_logic
#(
   parameter PAIRS = 4
)
(
   // Clock and reset
   input wire clock_i,
   input wire srst_i,
   // Indirect register port
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   // Address match values
   input wire [8*PAIRS-1:0] first_match_i,
   input wire [8*PAIRS-1:0] second_match_i,
   // Receive framing events
   input wire rx_flag_i,
   input wire rx_abort_i,
   input wire rx_byte_i,
   input wire [7:0] rx_data_i,
   // Transmit framing events
   input wire tx_closing_flag_i,
   input wire tx_abort_sent_i,
   // Operating state
   input wire idle_mode_i,
   input wire loop_local_i,
   input wire loop_liu_i,
   input wire backoff_active_i,
   // Mode outputs
   output reg [4:0] rx_threshold_o,
   output reg [3:0] tx_threshold_o,
   output reg flag_idle_o,
   output reg irq_o
);

   reg [7:0] mode_one_r;
   reg [7:0] mode_three_r;
   reg [7:0] mode_four_r;
   reg [7:0] ext_fifo_r;
   reg [7:0] status_r;
   reg [7:0] status_nxt;
   reg [3:0] addr_status_r;
   reg [3:0] addr_status_nxt;
   reg [1:0] byte_cnt_r;
   reg [7:0] byte_one_r;
   reg [2:0] loop_in_sync_r;
   reg [2:0] loop_liu_sync_r;
   reg [2:0] backoff_sync_r;
   reg [4:0] rx_thr_nxt;
   reg [3:0] tx_thr_nxt;
   reg [7:0] rdata_nxt;
   wire [PAIRS-1:0] match;
   wire rd_status;
   wire rd_addr;
   wire rd_rcount;
   wire wr_tcount;
   wire opening_byte;
   wire second_byte;
   wire closing_flag;
   wire addr_event;

   assign rd_status = reg_rd_i && reg_addr_i == `DMS_ADDR_STATUS_ONE;
   assign rd_addr = reg_rd_i && reg_addr_i == `DMS_ADDR_ADDR_STATUS;
   assign rd_rcount = reg_rd_i && reg_addr_i == `DMS_ADDR_RECV_COUNT;
   assign wr_tcount = reg_wr_i && reg_addr_i == `DMS_ADDR_XMIT_COUNT;

   // Byte count after the opening flag; saturates once address is done
   assign opening_byte = rx_byte_i && byte_cnt_r == 2'd0;
   assign second_byte = rx_byte_i && byte_cnt_r == 2'd1;
   assign closing_flag = rx_flag_i && byte_cnt_r != 2'd0;

   dms_addr_match #(.PAIRS(PAIRS)) u_match
   (
      .byte_one_i(byte_one_r),
      .byte_two_i(rx_data_i),
      .first_match_i(first_match_i),
      .second_match_i(second_match_i),
      .pair_en_i(mode_one_r[7:8-PAIRS]),
      .single_i(mode_four_r[`DMS_M4_SINGLE]),
      .second_only_i(mode_four_r[`DMS_M4_SECOND]),
      .cr_cmp_i(mode_four_r[`DMS_M4_CR_CMP]),
      .match_o(match)
   );

   // With no pair enabled the second byte marks end of address
   assign addr_event = second_byte &&
                       (|match || !(|mode_one_r[7:8-PAIRS]));

   always @(posedge clock_i)
   begin
      if (srst_i)
      begin
         byte_cnt_r <= 2'd0;
         byte_one_r <= 8'h00;
      end
      else if (rx_flag_i || rx_abort_i || idle_mode_i)
      begin
         byte_cnt_r <= 2'd0;
      end
      else if (rx_byte_i && byte_cnt_r != 2'd2)
      begin
         byte_cnt_r <= byte_cnt_r + 2'd1;
         if (opening_byte)
         begin
            byte_one_r <= rx_data_i;
         end
      end
   end

   // Loopback and back-off levels are asynchronous to this clock
   always @(posedge clock_i)
   begin
      if (srst_i)
      begin
         loop_in_sync_r <= 3'b000;
         loop_liu_sync_r <= 3'b000;
         backoff_sync_r <= 3'b000;
      end
      else
      begin
         loop_in_sync_r <= {loop_in_sync_r[1:0], loop_local_i};
         loop_liu_sync_r <= {loop_liu_sync_r[1:0], loop_liu_i};
         backoff_sync_r <= {backoff_sync_r[1:0], backoff_active_i};
      end
   end

   // Set wins over each read or write clear, so an event in a read cycle is kept; a flag or abort clear of bit 2 wins over its set
   always @*
   begin
      status_nxt = status_r;
      if (rd_status || rd_rcount)
      begin
         status_nxt[`DMS_S_ADDR] = 1'b0;
         status_nxt[`DMS_S_EOP] = 1'b0;
      end
      if (rd_status || wr_tcount)
      begin
         status_nxt[`DMS_S_TXEND] = 1'b0;
         status_nxt[`DMS_S_TXABORT] = 1'b0;
      end
      if (rx_flag_i || rx_abort_i)
      begin
         status_nxt[`DMS_S_RIP] = 1'b0;
      end
      if (addr_event)
      begin
         status_nxt[`DMS_S_ADDR] = 1'b1;
      end
      if (closing_flag)
      begin
         status_nxt[`DMS_S_EOP] = 1'b1;
      end
      if (opening_byte && !rx_flag_i && !rx_abort_i)
      begin
         status_nxt[`DMS_S_RIP] = 1'b1;
      end
      if (tx_closing_flag_i)
      begin
         status_nxt[`DMS_S_TXEND] = 1'b1;
      end
      if (tx_abort_sent_i)
      begin
         status_nxt[`DMS_S_TXABORT] = 1'b1;
      end
      status_nxt[`DMS_S_LOOP_IN] = loop_in_sync_r[2];
      status_nxt[`DMS_S_LOOP_LIU] = loop_liu_sync_r[2];
      status_nxt[`DMS_S_NO_BACKOFF] = !backoff_sync_r[2];
      addr_status_nxt = rd_addr ? 4'h0 : addr_status_r;
      if (second_byte)
      begin
         addr_status_nxt = addr_status_nxt | match;
      end
   end

   always @(posedge clock_i)
   begin
      if (srst_i || idle_mode_i)
      begin
         status_r <= 8'h00;
         addr_status_r <= 4'h0;
      end
      else
      begin
         status_r <= status_nxt;
         addr_status_r <= addr_status_nxt;
      end
   end

   // Writable mode registers; thresholds are only meant to move in idle
   always @(posedge clock_i)
   begin
      if (srst_i)
      begin
         mode_one_r <= `DMS_MODE_ONE_RST;
         mode_three_r <= `DMS_MODE_THREE_RST;
         mode_four_r <= `DMS_MODE_FOUR_RST;
         ext_fifo_r <= `DMS_EXT_FIFO_RST;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `DMS_ADDR_MODE_ONE: mode_one_r <= reg_wdata_i;
            `DMS_ADDR_MODE_THREE: mode_three_r <= reg_wdata_i;
            `DMS_ADDR_MODE_FOUR: mode_four_r <= reg_wdata_i;
            `DMS_ADDR_EXT_FIFO: ext_fifo_r <= reg_wdata_i;
            default: mode_one_r <= mode_one_r;
         endcase
      end
   end

   always @*
   begin
      if (ext_fifo_r[`DMS_EF_EXT])
      begin
         case (mode_four_r[1:0])
            2'b00: rx_thr_nxt = `DMS_RX_E0;
            2'b01: rx_thr_nxt = `DMS_RX_E1;
            2'b10: rx_thr_nxt = `DMS_RX_E2;
            default: rx_thr_nxt = `DMS_RX_E3;
         endcase
         case (mode_four_r[3:2])
            2'b00: tx_thr_nxt = `DMS_TX_E0;
            2'b01: tx_thr_nxt = `DMS_TX_E1;
            2'b10: tx_thr_nxt = `DMS_TX_E2;
            default: tx_thr_nxt = `DMS_TX_E3;
         endcase
      end
      else
      begin
         case (mode_four_r[1:0])
            2'b00: rx_thr_nxt = `DMS_RX_N0;
            2'b01: rx_thr_nxt = `DMS_RX_N1;
            2'b10: rx_thr_nxt = `DMS_RX_N2;
            default: rx_thr_nxt = `DMS_RX_N3;
         endcase
         case (mode_four_r[3:2])
            2'b00: tx_thr_nxt = `DMS_TX_N0;
            2'b01: tx_thr_nxt = `DMS_TX_N1;
            2'b10: tx_thr_nxt = `DMS_TX_N2;
            default: tx_thr_nxt = `DMS_TX_N3;
         endcase
      end
   end

   // Unmapped addresses read as zero
   always @*
   begin
      case (reg_addr_i)
         `DMS_ADDR_MODE_ONE: rdata_nxt = mode_one_r;
         `DMS_ADDR_MODE_THREE: rdata_nxt = mode_three_r;
         `DMS_ADDR_MODE_FOUR: rdata_nxt = mode_four_r;
         `DMS_ADDR_EXT_FIFO: rdata_nxt = ext_fifo_r;
         `DMS_ADDR_STATUS_ONE: rdata_nxt = status_r;
         `DMS_ADDR_ADDR_STATUS: rdata_nxt = {4'h0, addr_status_r};
         default: rdata_nxt = 8'h00;
      endcase
   end

   always @(posedge clock_i)
   begin
      if (srst_i)
      begin
         reg_rdata_o <= 8'h00;
         rx_threshold_o <= `DMS_RX_N0;
         tx_threshold_o <= `DMS_TX_N0;
         flag_idle_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         if (reg_rd_i)
         begin
            reg_rdata_o <= rdata_nxt;
         end
         rx_threshold_o <= rx_thr_nxt;
         tx_threshold_o <= tx_thr_nxt;
         flag_idle_o <= mode_four_r[`DMS_M4_FILL];
         irq_o <= (status_r[`DMS_S_ADDR] & mode_three_r[`DMS_M3_ADDR_IE]) |
                  (status_r[`DMS_S_EOP] & mode_one_r[`DMS_M1_EOP_IE]) |
                  (status_r[`DMS_S_TXEND] &
                   mode_three_r[`DMS_M3_TXEND_IE]);
      end
   end

endmodule

`default_nettype wire

// ---- testbench/dms_line_model.sv ----
/* Far-side line model: framing events as one-cycle pulses.
   Assumes the bench calls send between clock edges. */
`default_nettype none
module dms_line_model (
   // Clock
   input wire logic clock_i,
   // Receive events
   output logic rx_flag_o,
   output logic rx_abort_o,
   output logic rx_byte_o,
   output logic [7:0] rx_data_o,
   // Transmit events
   output logic tx_closing_flag_o,
   output logic tx_abort_sent_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      {tx_abort_sent_o, tx_closing_flag_o, rx_abort_o} = 3'h0;
      {rx_byte_o, rx_flag_o} = 2'h0;
      rx_data_o = 8'h5A;
   end
   // Data turns over outside a byte so stale values never match
   task automatic send(input logic [4:0] ev, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      {tx_abort_sent_o, tx_closing_flag_o, rx_abort_o, rx_byte_o} = ev[4:1];
      rx_flag_o = ev[0];
      rx_data_o = ev[1] ? d : ~rx_data_o;
      @(posedge clock_i);
      #1;
      {tx_abort_sent_o, tx_closing_flag_o, rx_abort_o} = 3'h0;
      {rx_byte_o, rx_flag_o} = 2'h0;
      rx_data_o = ~rx_data_o;
   endtask
endmodule
`default_nettype wire

// ---- testbench/dms_status_logic_tb.sv ----
/* Self-checking bench for dms_status_logic with the line model.
   Assumes the checker is bound in from its own file. */
`default_nettype none
module dms_status_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i, srst_i, reg_wr_i, reg_rd_i, idle_mode_i, irq_o;
   logic loop_local_i, loop_liu_i, backoff_active_i, flag_idle_o;
   logic rx_flag_i, rx_abort_i, rx_byte_i, tx_closing_flag_i, tx_abort_sent_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rx_data_i;
   logic [31:0] first_match_i, second_match_i;
   logic [4:0] rx_threshold_o;
   logic [3:0] tx_threshold_o;
   int mismatches, total_checks;
   logic [4:0] rxe [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h01, 5'h10, 5'h18,
      5'h1E};
   logic [3:0] txe [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h6, 4'hA, 4'hE};
   logic [39:0] rows [7] = '{40'h18003CC501, 40'h18203C0001, 40'h18A000C501,
      40'h18003EC501, 40'h18403EC500, 40'h18003C0000, 40'h0800112200};
   dms_status_logic uut (.clock_i, .srst_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .first_match_i, .second_match_i,
      .rx_flag_i, .rx_abort_i, .rx_byte_i, .rx_data_i, .tx_closing_flag_i,
      .tx_abort_sent_i, .idle_mode_i, .loop_local_i, .loop_liu_i,
      .backoff_active_i, .rx_threshold_o, .tx_threshold_o, .flag_idle_o,
      .irq_o);
   dms_line_model line (.clock_i, .rx_flag_o(rx_flag_i),
      .rx_abort_o(rx_abort_i), .rx_byte_o(rx_byte_i), .rx_data_o(rx_data_i),
      .tx_closing_flag_o(tx_closing_flag_i),
      .tx_abort_sent_o(tx_abort_sent_i));
   initial
   begin
      clock_i = 0;
      forever #4 clock_i = ~clock_i;
   end
   task automatic check(input string what, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clock_i);
      #1;
      {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
      @(posedge clock_i);
      #1;
      reg_wr_i = 0;
   endtask
   task automatic rd(input logic [7:0] a, exp);
      @(posedge clock_i);
      #1;
      {reg_addr_i, reg_rd_i} = {a, 1'b1};
      @(posedge clock_i);
      #1;
      reg_rd_i = 0;
      check($sformatf("reg %h", a), exp, reg_rdata_o);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_defaults;
      rd(8'h8F, 8'h00);
      rd(8'h8E, 8'h03);
      rd(8'h92, 8'h00);
      rd(8'h90, 8'h20);
      rd(8'h91, 8'h00);
      rd(8'h80, 8'h00);
   endtask
   task automatic t_thresholds;
      logic [7:0] d;
      idle_mode_i = 1;
      for (int i = 0; i < 8; i++)
      begin
         d = {3'h0, i[0], i[1:0], i[1:0]};
         wr(8'h92, {7'h0, i[2]});
         wr(8'h8F, d);
         rd(8'h8F, d);
         check("rx thr", {3'h0, rxe[i]}, {3'h0, rx_threshold_o});
         check("tx thr", {4'h0, txe[i]}, {4'h0, tx_threshold_o});
         check("fill", {7'h0, i[0]}, {7'h0, flag_idle_o});
      end
      wr(8'h92, 8'h00);
      wr(8'h8F, 8'h00);
      idle_mode_i = 0;
   endtask
   // Pair one only; the other pairs stay disabled
   task automatic t_rx;
      logic [39:0] r;
      for (int i = 0; i < 7; i++)
      begin
         r = rows[i];
         wr(8'h86, r[39:32]);
         wr(8'h8F, r[31:24]);
         line.send(5'h01, 8'h00);
         line.send(5'h02, r[23:16]);
         rd(8'h90, 8'h24);
         line.send(5'h02, r[15:8]);
         line.send(5'h01, 8'h00);
         rd(8'h91, r[7:0]);
         check("irq set", 8'h01, {7'h0, irq_o});
         rd(8'h90, {7'h11, r[7:0] != 0 || r[39:36] == 0});
         @(posedge clock_i);
         #1;
         check("irq clear", 8'h00, {7'h0, irq_o});
      end
      wr(8'h86, 8'h00);
      wr(8'h8F, 8'h00);
   endtask
   task automatic t_tx;
      line.send(5'h08, 8'h00);
      @(posedge clock_i);
      #1;
      check("tx irq", 8'h01, {7'h0, irq_o});
      wr(8'h85, 8'h00);
      @(posedge clock_i);
      #1;
      check("tx load", 8'h00, {7'h0, irq_o});
      line.send(5'h10, 8'h00);
      @(posedge clock_i);
      #1;
      check("abort irq", 8'h00, {7'h0, irq_o});
      rd(8'h90, 8'hA0);
      wr(8'h8E, 8'h00);
      line.send(5'h08, 8'h00);
      @(posedge clock_i);
      #1;
      check("masked", 8'h00, {7'h0, irq_o});
      rd(8'h90, 8'h60);
      line.send(5'h10, 8'h00);
      wr(8'h85, 8'h00);
      rd(8'h90, 8'h20);
      wr(8'h8E, 8'h03);
   endtask
   task automatic t_live;
      loop_local_i = 1;
      repeat (4) @(posedge clock_i);
      rd(8'h90, 8'h28);
      {loop_local_i, loop_liu_i} = 2'h1;
      repeat (4) @(posedge clock_i);
      rd(8'h90, 8'h30);
      {loop_liu_i, backoff_active_i} = 2'h1;
      repeat (4) @(posedge clock_i);
      rd(8'h90, 8'h00);
      backoff_active_i = 0;
      line.send(5'h01, 8'h00);
      line.send(5'h02, 8'h3C);
      line.send(5'h04, 8'h00);
      rd(8'h90, 8'h20);
      line.send(5'h01, 8'h00);
      line.send(5'h02, 8'h3C);
      line.send(5'h02, 8'h3C);
      line.send(5'h01, 8'h00);
      rd(8'h89, 8'h00);
      rd(8'h90, 8'h20);
      line.send(5'h01, 8'h00);
      line.send(5'h02, 8'h3C);
      line.send(5'h08, 8'h00);
      idle_mode_i = 1;
      repeat (2) @(posedge clock_i);
      #1;
      idle_mode_i = 0;
      rd(8'h90, 8'h20);
   endtask
   initial
   begin
      {srst_i, reg_wr_i, reg_rd_i, idle_mode_i} = 4'h8;
      {loop_local_i, loop_liu_i, backoff_active_i} = 3'h0;
      {reg_addr_i, reg_wdata_i} = 16'h0000;
      first_match_i = 32'h0000003C;
      second_match_i = 32'h000000C5;
      repeat (6) @(posedge clock_i);
      #1;
      srst_i = 0;
      t_defaults();
      t_thresholds();
      t_rx();
      t_tx();
      t_live();
      conclude();
   end
   // Whole run is well under a thousand cycles
   initial
   begin
      #40000;
      mismatches++;
      conclude();
   end
endmodule
`default_nettype wire

// ---- testbench/dms_status_sva.sv ----
/* Port checker for the D-channel mode and status logic.
   Assumes one clock and the sync reset of dms_status_logic. */
`default_nettype none
module dms_status_sva (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Events and state
   input wire logic rx_flag_i,
   input wire logic rx_byte_i,
   input wire logic tx_closing_flag_i,
   input wire logic idle_mode_i,
   // Mode outputs
   input wire logic [4:0] rx_threshold_o,
   input wire logic [3:0] tx_threshold_o,
   input wire logic flag_idle_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence s_m4_wr;
      reg_wr_i && reg_addr_i == 8'h8F ##1 !(reg_wr_i && reg_addr_i == 8'h8F);
   endsequence
   property p_fill;
      s_m4_wr |=> flag_idle_o == $past(reg_wdata_i[4], 2);
   endproperty
   property p_zero;
      s_m4_wr |=>
         ($past(reg_wdata_i[1:0], 2) != 2'h0 || rx_threshold_o == 5'h01)
         && ($past(reg_wdata_i[3:2], 2) != 2'h0 || tx_threshold_o == 4'h1);
   endproperty
   property p_idle;
      idle_mode_i [*2] |-> ##1 !irq_o;
   endproperty
   property p_reset;
      $fell(srst_i) |-> rx_threshold_o == 5'h01 && tx_threshold_o == 4'h1
         && !flag_idle_o && !irq_o && reg_rdata_o == 8'h00;
   endproperty
   property p_unmapped;
      reg_rd_i && !(reg_addr_i inside {[8'h85:8'h92]})
         |=> reg_rdata_o == 8'h00;
   endproperty
   property p_hold;
      !reg_rd_i |=> $stable(reg_rdata_o);
   endproperty
   // Only an event or a mode write can raise the request, two edges on
   property p_irq_cause;
      $rose(irq_o) |-> $past(rx_byte_i || rx_flag_i || tx_closing_flag_i
         || reg_wr_i, 2);
   endproperty
   property p_thr;
      !$stable({rx_threshold_o, tx_threshold_o}) |-> $past(reg_wr_i
         && (reg_addr_i == 8'h8F || reg_addr_i == 8'h92), 2);
   endproperty
   a_fill: assert property (p_fill)
      else $error("fill level wrong");
   a_zero: assert property (p_zero)
      else $error("code zero threshold wrong");
   a_idle: assert property (p_idle)
      else $error("request during idle");
   a_reset: assert property (p_reset)
      else $error("reset values wrong");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_hold: assert property (p_hold)
      else $error("read data moved");
   a_irq_cause: assert property (p_irq_cause)
      else $error("request without cause");
   a_thr: assert property (p_thr)
      else $error("threshold moved without write");
endmodule
bind dms_status_logic dms_status_sva chk (.clock_i, .srst_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_flag_i, .rx_byte_i,
   .tx_closing_flag_i, .idle_mode_i, .rx_threshold_o, .tx_threshold_o,
   .flag_idle_o, .irq_o);
`default_nettype wire
